/* hw/wdg_dummy_removed.sv */
// intentionally empty
`default_nettype none
`default_nettype wire

/* hw/wdg_pkg.sv */
// constants shared by the windowed watchdog and its timeout calculator
// Operation
// - The countdown value decrements once per 16384 oscillator clock cycles.
// - The low six bits of the countdown value select one of 64 timeout steps.
// - When active and the count rolls from 40h to 3Fh, a reset cycle starts.
// - The count decrements even while inactive; only the reset is gated.
// - A control register write leaves the prescaler phase untouched.
// - The watchdog leaves reset inactive unless the hardware strap is set, and cannot be deactivated after.
// - Writing activation set with the top counter bit clear resets at once.
// - While active, a halt instruction resets when the halt option is set.
// - A strap outside software selects the hardware-enabled watchdog mode.
// - Minimum base is (fine+128)*64, maximum base 16384, count is the field.
// - Timebase 00..11 gives coarse/fine 4/59, 8/53, 20/35 and 49/54.
// - Minimum timeout splits at a quarter of coarse with long steps beyond.
// - Maximum timeout uses the same split with a less-or-equal comparison.
// - The hardware-enabled mode keeps the watchdog always active.
// - Activation is set only by software; the register resets to 7Fh.
`default_nettype none
package wdg_pkg;
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CNT_W = 7;
	localparam int FIELD_W = 6;
	localparam int TB_W = 2;
	localparam int PRESC_W = 14;
	localparam int TIME_W = 21;
	localparam int HOLD_W = 16;
	// register map
	localparam logic [15:0] CTRL_ADDR = 16'h002a;
	localparam logic [15:0] TB_ADDR = 16'h002b;
	localparam logic [15:0] TMIN_LO_ADDR = 16'h002c;
	localparam logic [15:0] TMIN_MID_ADDR = 16'h002d;
	localparam logic [15:0] TMIN_HI_ADDR = 16'h002e;
	localparam logic [15:0] TMAX_LO_ADDR = 16'h002f;
	localparam logic [15:0] TMAX_MID_ADDR = 16'h0030;
	localparam logic [15:0] TMAX_HI_ADDR = 16'h0031;
	localparam logic [15:0] STAT_ADDR = 16'h0032;
	// control register fields
	localparam int ACT_BIT = 7;
	localparam int TOP_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h7f;
	localparam logic [6:0] ROLL_FROM = 7'h40;
	localparam logic [6:0] CNT_ONE = 7'h01;
	localparam logic [1:0] TB_RESET = 2'h0;
	// status register fields
	localparam int ST_ROLL = 0;
	localparam int ST_SW = 1;
	localparam int ST_HALT = 2;
	localparam int ST_ACTIVE = 4;
	localparam int ST_HWOPT = 5;
	localparam int ST_PIN = 6;
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	// prescaler
	localparam logic [13:0] PRESC_LAST = 14'h3fff;
	localparam logic [13:0] PRESC_ONE = 14'h0001;
	// timeout arithmetic, in oscillator periods
	localparam int MIN_BASE_OFF = 128;
	localparam int STEP_OSC = 64;
	localparam int MAX_BASE = 16384;
	localparam int STEP_PERIODS = 16384;
	localparam int LONG_OFF = 192;
	localparam int QUARTER = 4;
	localparam int COARSE_0 = 4;
	localparam int COARSE_1 = 8;
	localparam int COARSE_2 = 20;
	localparam int COARSE_3 = 49;
	localparam int FINE_0 = 59;
	localparam int FINE_1 = 53;
	localparam int FINE_2 = 35;
	localparam int FINE_3 = 54;
	// reset pin hold time
	localparam int CLK_PERIOD_NS = 4;
	localparam int RST_HOLD_US = 30;
	localparam int RST_HOLD_CYC = (RST_HOLD_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* hw/wdg_timeout_calc.sv */
// exact minimum and maximum timeout from timebase and count field
`default_nettype none
module wdg_timeout_calc (
	// selection
	input wire logic [wdg_pkg::TB_W-1:0] timebase_select,
	input wire logic [wdg_pkg::FIELD_W-1:0] timeout_count,
	// results in oscillator periods
	output logic [wdg_pkg::TIME_W-1:0] timeout_min,
	output logic [wdg_pkg::TIME_W-1:0] timeout_max
);
	import wdg_pkg::*;

	int coarse;
	int fine;
	int quarter_lim;
	logic [FIELD_W-1:0] long_steps;
	logic [TIME_W-1:0] min_base;
	logic [TIME_W-1:0] max_base;

	// base plus short steps plus long steps
	function automatic logic [TIME_W-1:0] wdg_span(
		input logic [TIME_W-1:0] base,
		input logic [FIELD_W-1:0] cnt,
		input logic [FIELD_W-1:0] q,
		input int fine_off
	);
		logic [TIME_W-1:0] short_part;
		logic [TIME_W-1:0] long_part;
		short_part = TIME_W'(STEP_PERIODS) * TIME_W'(cnt - q);
		long_part = TIME_W'((LONG_OFF + fine_off) * STEP_OSC) * TIME_W'(q);
		return base + short_part + long_part;
	endfunction

	always_comb begin
		unique case (timebase_select)
			2'h0: begin
				coarse = COARSE_0;
				fine = FINE_0;
			end
			2'h1: begin
				coarse = COARSE_1;
				fine = FINE_1;
			end
			2'h2: begin
				coarse = COARSE_2;
				fine = FINE_2;
			end
			2'h3: begin
				coarse = COARSE_3;
				fine = FINE_3;
			end
		endcase
	end

	always_comb begin
		// divisions round down
		quarter_lim = coarse / QUARTER;
		long_steps = FIELD_W'((QUARTER * int'(timeout_count)) / coarse);
		min_base = TIME_W'((fine + MIN_BASE_OFF) * STEP_OSC);
		max_base = TIME_W'(MAX_BASE);
		if (int'(timeout_count) < quarter_lim) begin
			timeout_min = wdg_span(min_base, timeout_count, '0, fine);
		end else begin
			timeout_min = wdg_span(min_base, timeout_count, long_steps, fine);
		end
		if (int'(timeout_count) <= quarter_lim) begin
			timeout_max = wdg_span(max_base, timeout_count, '0, fine);
		end else begin
			timeout_max = wdg_span(max_base, timeout_count, long_steps, fine);
		end
	end
endmodule
`default_nettype wire

/* hw/wdg_top.sv */
// windowed watchdog: prescaler, down-counter, reset generation, registers
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`default_nettype none
module wdg_top #(
	parameter int unsigned RST_HOLD_CYCLES = wdg_pkg::RST_HOLD_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	// register port
	input wire logic [wdg_pkg::ADDR_W-1:0] addr,
	input wire logic [wdg_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [wdg_pkg::DATA_W-1:0] rdata,
	// cpu and option straps
	input wire logic halt_executed,
	input wire logic hw_watchdog_option,
	input wire logic halt_reset_option,
	// chip reset
	output logic reset_pin_n,
	output logic reset_request
);
	import wdg_pkg::*;

	// prescaler and counter state
	logic [PRESC_W-1:0] presc_reg;
	logic [PRESC_W-1:0] presc_next;
	logic [CNT_W-1:0] counter_reg;
	logic [CNT_W-1:0] counter_next;
	logic activation_bit_reg;
	logic activation_bit_next;
	// straps
	logic strap_done_reg;
	logic strap_done_next;
	logic hw_opt_reg;
	logic hw_opt_next;
	logic halt_opt_reg;
	logic halt_opt_next;
	// reset generation
	logic [HOLD_W-1:0] hold_reg;
	logic [HOLD_W-1:0] hold_next;
	logic reset_pin_n_reg;
	logic reset_pin_n_next;
	logic reset_request_reg;
	logic reset_request_next;
	logic [2:0] cause_reg;
	logic [2:0] cause_next;
	// configuration and read back
	logic [TB_W-1:0] timebase_select_reg;
	logic [TB_W-1:0] timebase_select_next;
	logic [TIME_W-1:0] tmin_reg;
	logic [TIME_W-1:0] tmax_reg;
	logic [TIME_W-1:0] tmin_calc;
	logic [TIME_W-1:0] tmax_calc;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	// decoded events
	logic ctrl_wr;
	logic stat_wr;
	logic tb_wr;
	logic tick;
	logic active;
	logic roll_ev;
	logic sw_ev;
	logic halt_ev;
	logic any_ev;
	logic [7:0] status_byte;

	// byte of a timeout value, zero above its width
	function automatic logic [DATA_W-1:0] time_byte(
		input logic [TIME_W-1:0] t,
		input int idx
	);
		logic [23:0] wide;
		wide = {3'h0, t};
		return wide[idx*DATA_W +: DATA_W];
	endfunction

	wdg_timeout_calc u_calc (
		.timebase_select(timebase_select_reg),
		.timeout_count(counter_reg[FIELD_W-1:0]),
		.timeout_min(tmin_calc),
		.timeout_max(tmax_calc)
	);

	// decode and events
	always_comb begin
		ctrl_wr = wr && (addr == CTRL_ADDR);
		tb_wr = wr && (addr == TB_ADDR);
		stat_wr = wr && (addr == STAT_ADDR);
		tick = (presc_reg == PRESC_LAST);
		active = activation_bit_reg || hw_opt_reg;
		roll_ev = tick && !ctrl_wr && active
			&& (counter_reg == ROLL_FROM);
		sw_ev = ctrl_wr && (wdata[ACT_BIT] || hw_opt_reg)
			&& !wdata[TOP_BIT];
		halt_ev = halt_executed && active && halt_opt_reg;
		any_ev = roll_ev || sw_ev || halt_ev;
	end

	// prescaler, counter and activation
	always_comb begin
		presc_next = presc_reg + PRESC_ONE;
		counter_next = counter_reg;
		if (ctrl_wr) begin
			counter_next = wdata[CNT_W-1:0];
		end else if (tick) begin
			counter_next = counter_reg - CNT_ONE;
		end
		activation_bit_next = activation_bit_reg
			|| (ctrl_wr && wdata[ACT_BIT]);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			presc_reg <= '0;
			counter_reg <= CTRL_RESET[CNT_W-1:0];
			activation_bit_reg <= CTRL_RESET[ACT_BIT];
		end else if (clock_enable) begin
			presc_reg <= presc_next;
			counter_reg <= counter_next;
			activation_bit_reg <= activation_bit_next;
		end
	end

	// option straps caught after reset release
	always_comb begin
		strap_done_next = 1'b1;
		hw_opt_next = hw_opt_reg;
		halt_opt_next = halt_opt_reg;
		if (!strap_done_reg) begin
			hw_opt_next = hw_watchdog_option;
			halt_opt_next = halt_reset_option;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_done_reg <= 1'b0;
			hw_opt_reg <= 1'b0;
			halt_opt_reg <= 1'b0;
		end else if (clock_enable) begin
			strap_done_reg <= strap_done_next;
			hw_opt_reg <= hw_opt_next;
			halt_opt_reg <= halt_opt_next;
		end
	end

	// reset pulse, pin hold and cause flags
	always_comb begin
		reset_request_next = any_ev;
		if (any_ev) begin
			hold_next = HOLD_W'(RST_HOLD_CYCLES);
		end else if (hold_reg != '0) begin
			hold_next = hold_reg - HOLD_W'(1);
		end else begin
			hold_next = '0;
		end
		reset_pin_n_next = (hold_next == '0);
		cause_next = cause_reg;
		if (stat_wr) begin
			cause_next = cause_reg & ~wdata[2:0];
		end
		// set wins over clear
		cause_next = cause_next | {halt_ev, sw_ev, roll_ev};
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_reg <= '0;
			reset_pin_n_reg <= 1'b1;
			reset_request_reg <= 1'b0;
			cause_reg <= CAUSE_NONE;
		end else if (clock_enable) begin
			hold_reg <= hold_next;
			reset_pin_n_reg <= reset_pin_n_next;
			reset_request_reg <= reset_request_next;
			cause_reg <= cause_next;
		end
	end

	// configuration and read port
	always_comb begin
		timebase_select_next = timebase_select_reg;
		if (tb_wr) begin
			timebase_select_next = wdata[TB_W-1:0];
		end
		status_byte = '0;
		status_byte[ST_ROLL] = cause_reg[0];
		status_byte[ST_SW] = cause_reg[1];
		status_byte[ST_HALT] = cause_reg[2];
		status_byte[ST_ACTIVE] = active;
		status_byte[ST_HWOPT] = hw_opt_reg;
		status_byte[ST_PIN] = !reset_pin_n_reg;
		rdata_next = '0;
		if (rd) begin
			unique case (addr)
				CTRL_ADDR: rdata_next = {active, counter_reg};
				TB_ADDR: rdata_next = {6'h00, timebase_select_reg};
				TMIN_LO_ADDR: rdata_next = time_byte(tmin_reg, 0);
				TMIN_MID_ADDR: rdata_next = time_byte(tmin_reg, 1);
				TMIN_HI_ADDR: rdata_next = time_byte(tmin_reg, 2);
				TMAX_LO_ADDR: rdata_next = time_byte(tmax_reg, 0);
				TMAX_MID_ADDR: rdata_next = time_byte(tmax_reg, 1);
				TMAX_HI_ADDR: rdata_next = time_byte(tmax_reg, 2);
				STAT_ADDR: rdata_next = status_byte;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timebase_select_reg <= TB_RESET;
			tmin_reg <= '0;
			tmax_reg <= '0;
			rdata_reg <= '0;
		end else if (clock_enable) begin
			timebase_select_reg <= timebase_select_next;
			tmin_reg <= tmin_calc;
			tmax_reg <= tmax_calc;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign reset_pin_n = reset_pin_n_reg;
	assign reset_request = reset_request_reg;

	// checks
	AST_PRESC_TICK: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && tick && !ctrl_wr)
		|=> counter_reg == $past(counter_reg) - CNT_ONE)
		else $error("counter did not decrement on prescaler wrap");

	AST_HOLD_OFF_TICK: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && !tick && !ctrl_wr) |=> $stable(counter_reg))
		else $error("counter changed without a prescaler wrap");

	AST_ROLLOVER: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && tick && !ctrl_wr && active
			&& counter_reg == ROLL_FROM)
		|=> reset_request && !reset_pin_n)
		else $error("rollover while active gave no reset");

	AST_FREE_RUN: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && tick && !ctrl_wr && !active)
		|=> counter_reg != $past(counter_reg))
		else $error("inactive counter stopped");

	AST_PRESC_KEEP: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && ctrl_wr)
		|=> presc_reg == PRESC_W'($past(presc_reg) + PRESC_ONE))
		else $error("prescaler disturbed by control write");

	AST_STICKY_ACT: assert property (@(posedge clock) disable iff (rst)
		activation_bit_reg |=> activation_bit_reg)
		else $error("activation bit cleared without reset");

	AST_SW_RESET: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && ctrl_wr && wdata[ACT_BIT] && !wdata[TOP_BIT])
		|=> reset_request ##1 !reset_pin_n)
		else $error("software reset not produced");

	AST_HALT_RESET: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && halt_executed && active && halt_opt_reg)
		|=> reset_request)
		else $error("halt reset not produced");

	AST_HW_ACTIVE: assert property (@(posedge clock) disable iff (rst)
		(clock_enable && hw_opt_reg && ctrl_wr && !wdata[TOP_BIT])
		|=> reset_request)
		else $error("hardware mode ignored a software reset");

	AST_PULSE_CAUSE: assert property (@(posedge clock) disable iff (rst)
		$rose(reset_request) |-> $past(any_ev)
			&& $past(clock_enable))
		else $error("reset request without a cause");

	AST_PIN_WITH_REQ: assert property (@(posedge clock) disable iff (rst)
		reset_request |-> !reset_pin_n)
		else $error("request without pin low");
endmodule
`default_nettype wire

/* tb/tb_windowed_watchdog_timer.sv */
// self-checking bench for the windowed watchdog
`default_nettype none
module tb_windowed_watchdog_timer;
	timeunit 1ns;
	timeprecision 1ps;
	import wdg_pkg::*;
	localparam int HOLD = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clock_enable = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic halt_executed = 1'b0;
	logic hw_watchdog_option = 1'b0;
	logic halt_reset_option = 1'b0;
	logic [7:0] rdata;
	logic reset_pin_n;
	logic reset_request;
	int req_cnt;
	int low_len;
	int long_req;
	int error_cnt = 0;
	int n_checks = 0;
	int cnts [4] = '{0, 1, 12, 63};
	logic [7:0] d;
	logic [23:0] v;
	always #2 clock = ~clock;
	wdg_top #(.RST_HOLD_CYCLES(HOLD)) dut (
		.clock(clock), .rst(rst), .clock_enable(clock_enable),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.halt_executed(halt_executed),
		.hw_watchdog_option(hw_watchdog_option),
		.halt_reset_option(halt_reset_option),
		.reset_pin_n(reset_pin_n), .reset_request(reset_request)
	);
	wdg_reset_sink sink (
		.clock(clock), .reset_pin_n(reset_pin_n),
		.reset_request(reset_request), .req_cnt(req_cnt),
		.low_len(low_len), .long_req(long_req)
	);
	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
		@(posedge clock);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] x);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 x = rdata;
	endtask
	task automatic rd_tmo(input logic [15:0] a, output logic [23:0] x);
		logic [7:0] b0, b1, b2;
		rd_reg(a, b0);
		rd_reg(a + 16'h0001, b1);
		rd_reg(a + 16'h0002, b2);
		x = {b2, b1, b0};
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic halt_pulse;
		@(posedge clock);
		halt_executed <= 1'b1;
		@(posedge clock);
		halt_executed <= 1'b0;
		wait_cyc(3);
	endtask
	task automatic do_reset(input logic hw, input logic hlt);
		@(posedge clock);
		hw_watchdog_option <= hw;
		halt_reset_option <= hlt;
		rst <= 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		wait_cyc(2);
	endtask
	task automatic tend(input string name);
		$display("test %s done", name);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [23:0] tmo(input int tbs, input int cnt,
		input bit is_max);
		int coarse, fine, q, base;
		coarse = (tbs == 0) ? 4 : (tbs == 1) ? 8 : (tbs == 2) ? 20 : 49;
		fine = (tbs == 0) ? 59 : (tbs == 1) ? 53 : (tbs == 2) ? 35 : 54;
		base = is_max ? 16384 : (fine + 128) * 64;
		q = 4 * cnt / coarse;
		if (is_max ? (cnt <= coarse / 4) : (cnt < coarse / 4)) begin
			return 24'(base + 16384 * cnt);
		end
		return 24'(base + 16384 * (cnt - q) + (192 + fine) * 64 * q);
	endfunction
	initial begin
		repeat (80000) @(posedge clock);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		wait_cyc(2);
		rd_reg(CTRL_ADDR, d);
		chk("ctrl reset", 24'h7f, d);
		@(posedge clock);
		#1;
		chk("rdata idle", 24'h00, 24'(rdata));
		wr_reg(16'h0040, 8'hff);
		rd_reg(16'h0040, d);
		chk("unmapped", 24'h00, d);
		tend("reset values");
		// prescaler phase is fixed by reset: exactly one wrap in the wait
		wr_reg(CTRL_ADDR, 8'h40);
		wait_cyc(24576);
		rd_reg(CTRL_ADDR, d);
		chk("free run counter", 24'h3f, d);
		chk("inactive requests", 24'h0, 24'(req_cnt));
		tend("inactive rollover");
		wr_reg(CTRL_ADDR, 8'hc0);
		for (int i = 0; i < 16400 && reset_request !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		chk("rollover request", 24'h1, 24'(reset_request));
		rd_reg(CTRL_ADDR, d);
		chk("ctrl after roll", 24'hbf, d);
		for (int t = 0; t < 4; t++) begin
			wr_reg(TB_ADDR, 8'(t));
			rd_reg(TB_ADDR, d);
			chk("timebase", 24'(t), d);
			for (int k = 0; k < 4; k++) begin
				wr_reg(CTRL_ADDR, 8'h40 | 8'(cnts[k]));
				rd_tmo(TMIN_LO_ADDR, v);
				chk("tmin", tmo(t, cnts[k], 1'b0), v);
				rd_tmo(TMAX_LO_ADDR, v);
				chk("tmax", tmo(t, cnts[k], 1'b1), v);
			end
		end
		chk("pin low time", 24'(HOLD), 24'(low_len));
		chk("request one cycle", 24'h0, 24'(long_req));
		chk("request count", 24'h1, 24'(req_cnt));
		tend("timeouts");
		wr_reg(CTRL_ADDR, 8'h7f);
		rd_reg(CTRL_ADDR, d);
		chk("stay active", 24'hff, d);
		halt_pulse();
		chk("halt no option", 24'h1, 24'(req_cnt));
		wr_reg(STAT_ADDR, 8'h07);
		@(posedge clock);
		clock_enable <= 1'b0;
		wr_reg(CTRL_ADDR, 8'h80);
		clock_enable <= 1'b1;
		wait_cyc(3);
		chk("frozen write", 24'h1, 24'(req_cnt));
		wr_reg(CTRL_ADDR, 8'h80);
		wait_cyc(10);
		chk("sw reset", 24'h2, 24'(req_cnt));
		rd_reg(STAT_ADDR, d);
		chk("status sw", 24'h12, d);
		tend("software reset");
		do_reset(1'b0, 1'b1);
		rd_reg(CTRL_ADDR, d);
		chk("ctrl second reset", 24'h7f, d);
		halt_pulse();
		chk("halt inactive", 24'h2, 24'(req_cnt));
		wr_reg(CTRL_ADDR, 8'hff);
		halt_pulse();
		chk("halt reset", 24'h3, 24'(req_cnt));
		rd_reg(STAT_ADDR, d);
		chk("status halt", 24'h14, d);
		tend("halt");
		do_reset(1'b1, 1'b0);
		rd_reg(CTRL_ADDR, d);
		chk("hw mode ctrl", 24'hff, d);
		rd_reg(STAT_ADDR, d);
		chk("hw mode status", 24'h30, d);
		wr_reg(CTRL_ADDR, 8'h7f);
		wait_cyc(3);
		chk("hw mode refresh", 24'h3, 24'(req_cnt));
		wr_reg(CTRL_ADDR, 8'h00);
		wait_cyc(3);
		chk("hw mode sw reset", 24'h4, 24'(req_cnt));
		tend("hardware mode");
		final_report();
	end
endmodule
`default_nettype wire

/* tb/wdg_reset_sink.sv */
// chip reset logic model: counts reset requests and measures pin low time
`default_nettype none
module wdg_reset_sink (
	// clock
	input wire logic clock,
	// reset lines from the watchdog
	input wire logic reset_pin_n,
	input wire logic reset_request,
	// observations
	output int req_cnt,
	output int low_len,
	output int long_req
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_q = 0;
	int len_q = 0;
	int long_q = 0;
	int run_q = 0;
	logic prev_q = 1'b0;
	assign req_cnt = cnt_q;
	assign low_len = len_q;
	assign long_req = long_q;
	always @(posedge clock) begin
		if (reset_request === 1'b1) begin
			cnt_q <= cnt_q + 1;
		end
		if (reset_request === 1'b1 && prev_q === 1'b1) begin
			long_q <= long_q + 1;
		end
		prev_q <= reset_request;
		if (reset_pin_n === 1'b0) begin
			run_q <= run_q + 1;
		end else if (run_q != 0) begin
			len_q <= run_q;
			run_q <= 0;
		end
	end
endmodule
`default_nettype wire
